//--- sibc_pkg.sv
// Shared constants, register layouts and state types of the serial bus control block
package sibc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         ADDR_W   = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COND = 8'h04;
  localparam logic [7:0] OFS_TXD  = 8'h08;
  localparam logic [7:0] OFS_RXD  = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_BAUD = 8'h14;

  localparam int         HTRANS_ACT_BIT = 1;
  localparam logic       HRESP_OKAY     = 1'b0;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] BAUD_RST     = 8'h04;
  localparam logic [2:0] SMD_DISABLED = 3'h0;
  localparam logic [2:0] DLY_NONE     = 3'h0;
  localparam logic [3:0] BITS_DATA    = 4'h8;
  localparam logic [3:0] BIT_NINTH    = 4'h9;
  localparam logic [3:0] BIT_TENTH    = 4'ha;
  localparam logic [1:0] STEP_ONE     = 2'h1;
  localparam logic [1:0] STEP_TWO     = 2'h2;

  // ----------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [10:0] rsvd;
    logic        sda_init_level;
    logic        internal_clock;
    logic        ack_reception_source;
    logic        init_on_start_enable;
    logic        ack_drive_value;
    logic        ack_drive_select;
    logic        ack_interrupt_mode;
    logic        data_output_disable;
    logic [2:0]  data_delay_select;
    logic        clock_phase_select;
    logic        tenth_clock_hold;
    logic        clock_force_low;
    logic        release_on_stop;
    logic        ninth_clock_hold;
    logic        clock_sync_enable;
    logic [2:0]  serial_mode_field;
    logic        bus_mode_select;
  } sibc_ctrl_s;

  typedef struct packed {
    logic [27:0] rsvd;
    logic        condition_output_select;
    logic        stop_request;
    logic        restart_request;
    logic        start_request;
  } sibc_cond_s;

  typedef struct packed {
    logic [26:0] rsvd;
    logic        cond_busy;
    logic        xfer_active;
    logic        last_ack;
    logic        bus_busy;
    logic        tx_buffer_empty_flag;
  } sibc_stat_s;

  typedef enum logic [1:0] {CG_IDLE, CG_START, CG_RESTART, CG_STOP} sibc_cg_e;

endpackage : sibc_pkg

//--- sibc_top.sv
// Serial channel bus control in two-wire mode with an AHB-Lite register slave
`timescale 1ns/100ps

module sibc_top
  import sibc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clock_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        bus_clock_pin_i,
  output logic             bus_clock_pin_o,
  output logic             bus_clock_pin_oe_n,
  input  wire logic        bus_data_pin_i,
  output logic             bus_data_pin_o,
  output logic             bus_data_pin_oe_n,
  output logic             cond_event,
  output logic             ack_event,
  output logic             nack_event,
  output logic             transfer_controller_req
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sibc_ctrl_s  ctrl;
    sibc_cond_s  cond;
    logic [7:0]  txbuf;
    logic [7:0]  baud;
    logic        tx_empty;
    logic [8:0]  rxbuf;
    logic [7:0]  txsh;
    logic [7:0]  rxsh;
    logic [3:0]  bitcnt;
    logic        active;
    logic        tx_out;
    logic [7:0]  dly;
    logic [7:0]  bcnt;
    logic        int_scl;
    logic        hold9;
    logic        hold10;
    logic        last_ack;
    logic        busy;
    sibc_cg_e    cg;
    logic [1:0]  step;
    logic        cg_scl;
    logic        cg_sda;
    logic        scl_s1;
    logic        scl_s2;
    logic        sda_s1;
    logic        sda_s2;
    logic        scl_d;
    logic        sda_d;
    logic        tclk_d;
    logic        dph;
    logic        dwr;
    logic [7:0]  daddr;
    logic [31:0] rdata;
    logic        scl_low;
    logic        sda_low;
    logic        ev_cond;
    logic        ev_ack;
    logic        ev_nack;
    logic        ev_dtc;
  } sibc_state_s;

  sibc_state_s r;
  sibc_state_s n;

  logic       start_det;
  logic       stop_det;
  logic       scl_fall;
  logic       pause;
  logic       run;
  logic       tick;
  logic       tclk;
  logic       tclk_rise;
  logic       tclk_fall;
  logic       wr_txd;
  logic       dly_tap;
  logic [31:0] rd_mux;
  sibc_stat_s stat;

  // ----------------------------------------------------------------
  // Pin events
  // ----------------------------------------------------------------
  assign start_det = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
  assign stop_det  = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
  assign scl_fall  = r.scl_d & ~r.scl_s2;

  // Counting pauses while the internal clock is high but the pin is still low
  assign pause = r.ctrl.clock_sync_enable & r.int_scl & ~r.scl_s2;
  assign run   = (r.active & r.ctrl.internal_clock) | (r.cg != CG_IDLE);
  assign tick  = run & ~pause & (r.bcnt == 8'h00);

  // Internal clock gated by the pin; external clock is the pin itself
  assign tclk      = r.ctrl.internal_clock ? (r.int_scl & r.scl_s2) : r.scl_s2;
  assign tclk_rise = r.active & tclk & ~r.tclk_d;
  assign tclk_fall = r.active & ~tclk & r.tclk_d;

  assign wr_txd  = r.dph & r.dwr & (r.daddr == OFS_TXD);
  assign dly_tap = (r.ctrl.data_delay_select == DLY_NONE) ? r.tx_out
                                                          : r.dly[r.ctrl.data_delay_select];

  always_comb begin
    stat                      = '0;
    stat.tx_buffer_empty_flag = r.tx_empty;
    stat.bus_busy             = r.busy;
    stat.last_ack             = r.last_ack;
    stat.xfer_active          = r.active;
    stat.cond_busy            = (r.cg != CG_IDLE);
    case (haddr[ADDR_W-1:0])
      OFS_CTRL: rd_mux = r.ctrl;
      OFS_COND: rd_mux = r.cond;
      OFS_TXD:  rd_mux = {24'h000000, r.txbuf};
      OFS_RXD:  rd_mux = {23'h000000, r.rxbuf};
      OFS_STAT: rd_mux = stat;
      OFS_BAUD: rd_mux = {24'h000000, r.baud};
      default:  rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n         = r;
    n.ev_cond = 1'b0;
    n.ev_ack  = 1'b0;
    n.ev_nack = 1'b0;
    n.ev_dtc  = 1'b0;
    n.scl_s1  = bus_clock_pin_i;
    n.scl_s2  = r.scl_s1;
    n.sda_s1  = bus_data_pin_i;
    n.sda_s2  = r.sda_s1;
    n.scl_d   = r.scl_s2;
    n.sda_d   = r.sda_s2;
    n.tclk_d  = tclk;
    n.dly     = {r.dly[6:0], r.tx_out};

    // Bus slave: address phase captured, write applied in data phase
    n.dph = hsel & hready & htrans[HTRANS_ACT_BIT];
    if (hsel & hready & htrans[HTRANS_ACT_BIT]) begin
      n.dwr   = hwrite;
      n.daddr = haddr[ADDR_W-1:0];
      n.rdata = rd_mux;
    end
    if (r.dph & r.dwr) begin
      case (r.daddr)
        OFS_CTRL: begin
          n.ctrl      = sibc_ctrl_s'(hwdata);
          n.ctrl.rsvd = '0;
        end
        OFS_COND: begin
          n.cond      = sibc_cond_s'(hwdata);
          n.cond.rsvd = '0;
        end
        OFS_TXD: begin
          n.txbuf    = hwdata[7:0];
          n.tx_empty = 1'b0;
        end
        OFS_BAUD: n.baud = hwdata[7:0];
        default: ;
      endcase
    end

    // Bus busy tracking and detection events
    if (start_det) n.busy = 1'b1;
    if (stop_det) n.busy = 1'b0;
    if (~r.cond.condition_output_select & (start_det | stop_det)) n.ev_cond = 1'b1;

    // Baud divider and internal clock
    if (r.ctrl.clock_sync_enable & r.int_scl & scl_fall & r.active) begin
      n.int_scl = 1'b0;
      n.bcnt    = r.baud;
    end else if (run & ~pause) begin
      if (tick) begin
        n.bcnt = r.baud;
        if (r.active & r.ctrl.internal_clock) n.int_scl = ~r.int_scl;
      end else begin
        n.bcnt = r.bcnt - 8'h01;
      end
    end

    // Transfer engine
    if (start_det & r.ctrl.init_on_start_enable) begin
      n.txsh                  = r.txbuf;
      n.rxsh                  = 8'h00;
      n.bitcnt                = 4'h0;
      n.active                = 1'b1;
      n.hold9                 = 1'b0;
      n.hold10                = 1'b0;
      n.ctrl.ninth_clock_hold = 1'b1;
    end else if (~r.active & ~r.tx_empty & (r.ctrl.serial_mode_field != SMD_DISABLED)
                 & (r.cg == CG_IDLE)) begin
      // First bit goes out at once; the clock starts low so no stray pulse follows a start
      n.tx_out   = r.txbuf[7];
      n.txsh     = {r.txbuf[6:0], 1'b0};
      n.tclk_d   = 1'b0;
      n.cg_scl   = 1'b1;
      n.tx_empty = ~wr_txd;
      n.bitcnt   = 4'h0;
      n.active   = 1'b1;
      n.int_scl  = 1'b0;
      n.bcnt     = r.baud;
      n.hold9    = 1'b0;
      n.hold10   = 1'b0;
    end else begin
      if (tclk_fall) begin
        if (r.bitcnt < BITS_DATA) begin
          n.tx_out = r.txsh[7];
          n.txsh   = {r.txsh[6:0], 1'b0};
        end else if (r.bitcnt == BITS_DATA) begin
          n.tx_out = 1'b1;
          if (r.ctrl.ack_interrupt_mode) n.rxbuf = {r.rxsh[0], 1'b0, r.rxsh[7:1]};
        end else if (r.bitcnt == BIT_NINTH) begin
          if (r.ctrl.ninth_clock_hold) begin
            n.hold9  = 1'b1;
            n.active = 1'b0;
          end else if (~(r.ctrl.clock_phase_select & r.ctrl.tenth_clock_hold)) begin
            n.active  = 1'b0;
            n.int_scl = 1'b1;
          end
        end else begin
          n.hold10  = r.ctrl.clock_phase_select & r.ctrl.tenth_clock_hold;
          n.active  = 1'b0;
          n.int_scl = ~(r.ctrl.clock_phase_select & r.ctrl.tenth_clock_hold);
        end
      end
      if (tclk_rise & (r.bitcnt < BIT_TENTH)) begin
        n.bitcnt = r.bitcnt + 4'h1;
        if (r.bitcnt < BITS_DATA) n.rxsh = {r.rxsh[6:0], r.sda_s2};
        if (r.bitcnt == BITS_DATA) begin
          n.last_ack = ~r.sda_s2;
          if (~r.ctrl.ack_interrupt_mode) begin
            n.rxbuf   = {r.sda_s2, r.rxsh};
            n.ev_nack = r.sda_s2;
            n.ev_ack  = ~r.sda_s2;
          end else if (r.ctrl.clock_phase_select) begin
            n.rxbuf = {r.sda_s2, r.rxsh};
          end
          if (r.ctrl.ack_reception_source & ~r.sda_s2) n.ev_dtc = 1'b1;
        end
      end
    end

    if (stop_det & r.ctrl.release_on_stop) begin
      n.hold9   = 1'b0;
      n.hold10  = 1'b0;
      n.active  = 1'b0;
      n.int_scl = 1'b1;
    end

    // Condition generator, one divider period per step
    case (r.cg)
      CG_IDLE: begin
        if (r.cond.condition_output_select & ~r.active) begin
          n.step = 2'h0;
          n.bcnt = r.baud;
          if (r.cond.start_request) begin
            n.cg     = CG_START;
            n.cg_scl = 1'b1;
            n.cg_sda = 1'b1;
          end else if (r.cond.restart_request) begin
            n.cg     = CG_RESTART;
            n.cg_scl = 1'b0;
            n.cg_sda = 1'b1;
          end else if (r.cond.stop_request) begin
            n.cg     = CG_STOP;
            n.cg_scl = 1'b0;
            n.cg_sda = 1'b0;
          end
        end
      end
      CG_START: begin
        if (tick) begin
          n.step = r.step + STEP_ONE;
          if (r.step == 2'h0) begin
            n.cg_sda = 1'b0;
          end else begin
            n.cg_scl              = 1'b0;
            n.cg                  = CG_IDLE;
            n.cond.start_request  = 1'b0;
            n.ev_cond             = 1'b1;
          end
        end
      end
      CG_RESTART: begin
        if (tick) begin
          n.step = r.step + STEP_ONE;
          if (r.step == 2'h0) begin
            n.cg_scl = 1'b1;
          end else if (r.step == STEP_ONE) begin
            n.cg_sda = 1'b0;
          end else begin
            n.cg_scl               = 1'b0;
            n.cg                   = CG_IDLE;
            n.cond.restart_request = 1'b0;
            n.ev_cond              = 1'b1;
          end
        end
      end
      CG_STOP: begin
        if (tick) begin
          n.step = r.step + STEP_ONE;
          if (r.step == 2'h0) begin
            n.cg_scl = 1'b1;
          end else if (r.step == STEP_ONE) begin
            n.cg_sda = 1'b1;
          end else if (r.step == STEP_TWO) begin
            n.cg                = CG_IDLE;
            n.cond.stop_request = 1'b0;
            n.ev_cond           = 1'b1;
          end
        end
      end
      default: n.cg = CG_IDLE;
    endcase

    // Pin drive, registered so the pads see no glitches
    n.scl_low = r.ctrl.bus_mode_select &
                (r.ctrl.clock_force_low
                 | (r.hold9 & r.ctrl.ninth_clock_hold)
                 | (r.hold10 & r.ctrl.tenth_clock_hold)
                 | (r.cond.condition_output_select & ~r.cg_scl)
                 | (r.active & r.ctrl.internal_clock & ~r.int_scl));
    if (~r.ctrl.bus_mode_select | r.ctrl.data_output_disable) begin
      n.sda_low = 1'b0;
    end else if (r.ctrl.serial_mode_field == SMD_DISABLED) begin
      n.sda_low = ~r.ctrl.sda_init_level;
    end else if (r.cond.condition_output_select & ((r.cg != CG_IDLE) | ~r.cg_scl)) begin
      n.sda_low = ~r.cg_sda;
    end else if (~r.cond.condition_output_select & r.ctrl.ack_drive_select) begin
      n.sda_low = ~r.ctrl.ack_drive_value;
    end else begin
      n.sda_low = ~dly_tap;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r          <= '0;
      r.baud     <= BAUD_RST;
      r.tx_empty <= 1'b1;
      r.tx_out   <= 1'b1;
      r.int_scl  <= 1'b1;
      r.cg       <= CG_IDLE;
      r.cg_scl   <= 1'b1;
      r.cg_sda   <= 1'b1;
      r.scl_s1   <= 1'b1;
      r.scl_s2   <= 1'b1;
      r.sda_s1   <= 1'b1;
      r.sda_s2   <= 1'b1;
      r.scl_d    <= 1'b1;
      r.sda_d    <= 1'b1;
      r.dly      <= 8'hff;
    end else if (clock_en) begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata                  = r.rdata;
  assign hreadyout               = clock_en;
  assign hresp                   = HRESP_OKAY;
  assign bus_clock_pin_o         = 1'b0;
  assign bus_clock_pin_oe_n      = ~r.scl_low;
  assign bus_data_pin_o          = 1'b0;
  assign bus_data_pin_oe_n       = ~r.sda_low;
  assign cond_event              = r.ev_cond;
  assign ack_event               = r.ev_ack;
  assign nack_event              = r.ev_nack;
  assign transfer_controller_req = r.ev_dtc;

endmodule : sibc_top

//--- sibc_checker.sv
// Port-level assertions for the serial bus control block
`timescale 1ns/100ps

module sibc_checker
  import sibc_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        clock_en,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        bus_clock_pin_i,
  input wire logic        bus_clock_pin_o,
  input wire logic        bus_clock_pin_oe_n,
  input wire logic        bus_data_pin_i,
  input wire logic        bus_data_pin_o,
  input wire logic        bus_data_pin_oe_n,
  input wire logic        cond_event,
  input wire logic        ack_event,
  input wire logic        nack_event,
  input wire logic        transfer_controller_req
);
  // ----------------------------------------------------------------
  // Shadow of software writes
  // ----------------------------------------------------------------
  logic       ph_wr_r;
  logic [7:0] ph_a_r;
  sibc_ctrl_s ctrl_r;
  sibc_cond_s cond_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ph_wr_r <= 1'b0;
      ph_a_r  <= 8'h00;
      ctrl_r  <= '0;
      cond_r  <= '0;
    end else if (clock_en) begin
      if (ph_wr_r && ph_a_r == OFS_CTRL) ctrl_r <= sibc_ctrl_s'(hwdata);
      if (ph_wr_r && ph_a_r == OFS_COND) cond_r <= sibc_cond_s'(hwdata);
      ph_wr_r <= hsel && hready && htrans[HTRANS_ACT_BIT] && hwrite;
      ph_a_r  <= haddr[7:0];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_force_low; ctrl_r.bus_mode_select && ctrl_r.clock_force_low |-> ##[0:2] !bus_clock_pin_oe_n; endproperty
  a_force_low: assert property (p_force_low) else $error("clock not forced low");
  property p_sda_off; ctrl_r.bus_mode_select && ctrl_r.data_output_disable |-> ##[0:2] bus_data_pin_oe_n; endproperty
  a_sda_off: assert property (p_sda_off) else $error("data pin not floated");
  property p_ack_mode; (ack_event || nack_event) |-> !ctrl_r.ack_interrupt_mode && !(ack_event && nack_event); endproperty
  a_ack_mode: assert property (p_ack_mode) else $error("bad ack or nack event");
  property p_dtc;
    transfer_controller_req |-> ctrl_r.ack_reception_source && (ctrl_r.ack_interrupt_mode || ack_event);
  endproperty
  a_dtc: assert property (p_dtc) else $error("transfer request without ack");
  property p_detect;
    $fell(bus_data_pin_i) && bus_clock_pin_i && ctrl_r.bus_mode_select && !cond_r.condition_output_select
      |-> ##[1:6] cond_event;
  endproperty
  a_detect: assert property (p_detect) else $error("start not reported");
  property p_cond_pulse; cond_event |=> !cond_event; endproperty
  a_cond_pulse: assert property (p_cond_pulse) else $error("condition event too long");
  property p_ack_pulse; ack_event |=> !ack_event; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack event too long");
  property p_hold9;
    ack_event && ctrl_r.ninth_clock_hold |-> ##[1:12] !bus_clock_pin_oe_n ##1 !bus_clock_pin_oe_n [*8];
  endproperty
  a_hold9: assert property (p_hold9) else $error("clock not held after ninth bit");
endmodule : sibc_checker

bind sibc_top sibc_checker u_chk (.clock(clock), .rst_n(rst_n), .clock_en(clock_en), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .bus_clock_pin_i(bus_clock_pin_i), .bus_clock_pin_o(bus_clock_pin_o),
  .bus_clock_pin_oe_n(bus_clock_pin_oe_n), .bus_data_pin_i(bus_data_pin_i), .bus_data_pin_o(bus_data_pin_o),
  .bus_data_pin_oe_n(bus_data_pin_oe_n), .cond_event(cond_event), .ack_event(ack_event),
  .nack_event(nack_event), .transfer_controller_req(transfer_controller_req));

//--- sibc_partner.sv
// Behavioural slave on the two-wire bus that acknowledges the first byte after each start
`timescale 1ns/100ps

module sibc_partner (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic ack_en,
  output logic      sda_oe_n
);
  int   rises;
  logic active;

  initial begin
    sda_oe_n = 1'b1;
    rises    = 0;
    active   = 1'b0;
  end
  always @(negedge sda) if (scl) begin
    active = 1'b1;
    rises  = 0;
  end
  always @(posedge sda) if (scl) active = 1'b0;
  always @(posedge scl) if (active) rises++;
  // Pull data low for the ninth bit only
  always @(negedge scl) sda_oe_n <= !(active && ack_en && rises == 8);
endmodule : sibc_partner

//--- test_serial_i2c_bus_control.sv
// Self-checking testbench of the serial bus control block
`timescale 1ns/100ps

module test_serial_i2c_bus_control;
  import sibc_pkg::*;
  localparam logic [31:0] BASE = 32'h001c0023;
  logic        clock, rst_n, hsel, hwrite, tb_sda_low, saw_start, saw_stop;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic        hreadyout, hresp, scl_oe_n, scl_o, sda_oe_n, sda_o, p_sda_oe_n;
  logic        cond_event, ack_event, nack_event, dtc_req;
  logic [8:0]  cap;
  int          fails, n_compared, n_cond, n_ack, n_rise;
  wire         scl = (scl_oe_n !== 1'b0);
  wire         sda = (sda_oe_n !== 1'b0) && p_sda_oe_n && !tb_sda_low;

  sibc_top dut (.clock(clock), .rst_n(rst_n), .clock_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .bus_clock_pin_i(scl), .bus_clock_pin_o(scl_o), .bus_clock_pin_oe_n(scl_oe_n),
    .bus_data_pin_i(sda), .bus_data_pin_o(sda_o), .bus_data_pin_oe_n(sda_oe_n), .cond_event(cond_event),
    .ack_event(ack_event), .nack_event(nack_event), .transfer_controller_req(dtc_req));
  sibc_partner u_partner (.scl(scl), .sda(sda), .ack_en(1'b1), .sda_oe_n(p_sda_oe_n));

  // ----------------------------------------------------------------
  // Clock, reset and bus monitor
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) if (cond_event === 1'b1) n_cond++;
  always @(posedge clock) if (ack_event === 1'b1) n_ack++;
  always @(negedge sda) if (scl) begin
    saw_start = 1'b1;
    cap = 9'h000;
    n_rise = 0;
  end
  always @(posedge sda) if (scl) saw_stop = 1'b1;
  always @(posedge scl) begin
    cap = {cap[7:0], sda};
    n_rise++;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    ahb(1'b1, a, wd, rd);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h00000000, rd);
    check(rd, exp, msg);
  endtask : rd_chk

  task automatic wait_inc(ref int c, input int lim);
    int b;
    int i;
    b = c;
    i = 0;
    while (c == b && i < lim) begin
      @(posedge clock);
      i++;
    end
  endtask : wait_inc

  task automatic stop_test();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd_chk(OFS_CTRL, 32'h00000000, "ctrl reset");
    rd_chk(OFS_STAT, 32'h00000001, "stat reset");
    rd_chk(OFS_BAUD, 32'h00000004, "baud reset");
    rd_chk(8'h18, 32'h00000000, "unmapped read");
    wr(OFS_CTRL, 32'h00100001);
    wr(OFS_CTRL, BASE);
    rd_chk(OFS_CTRL, BASE, "ctrl readback");
  endtask : t_regs

  task automatic t_detect();
    int b;
    b = n_cond;
    @(posedge clock) tb_sda_low <= 1'b1;
    wait_inc(n_cond, 20);
    check(n_cond, b + 1, "start detect event");
    @(posedge clock) tb_sda_low <= 1'b0;
    wait_inc(n_cond, 20);
    check(n_cond, b + 2, "stop detect event");
  endtask : t_detect

  task automatic t_frame();
    int b;
    b = n_cond;
    saw_start = 1'b0;
    wr(OFS_COND, 32'h00000001);
    wr(OFS_COND, 32'h00000009);
    wait_inc(n_cond, 400);
    check(n_cond, b + 1, "start generated event");
    check(saw_start, 1'b1, "start on wire");
    rd_chk(OFS_COND, 32'h00000008, "request cleared");
    b = n_ack;
    wr(OFS_TXD, 32'h000000a5);
    wait_inc(n_ack, 600);
    check(n_ack, b + 1, "ack event");
    check(cap, {8'ha5, 1'b0}, "bits on wire");
    repeat (30) @(posedge clock);
    check(n_rise, 9, "clock pulse count");
    check(scl, 1'b0, "clock held after ninth");
    wr(OFS_CTRL, 32'h001c0003);
    repeat (8) @(posedge clock);
    check(scl, 1'b1, "clock freed when hold cleared");
    b = n_cond;
    saw_stop = 1'b0;
    wr(OFS_COND, 32'h0000000c);
    wait_inc(n_cond, 400);
    check(n_cond, b + 1, "stop generated event");
    check(saw_stop, 1'b1, "stop on wire");
  endtask : t_frame

  task automatic t_force();
    wr(OFS_CTRL, BASE | 32'h00002080);
    repeat (6) @(posedge clock);
    check(scl, 1'b0, "clock forced low");
    check(sda_oe_n, 1'b1, "data pin floated");
    wr(OFS_CTRL, BASE);
  endtask : t_force

  initial begin
    rst_n      = 1'b0;
    hsel       = 1'b0;
    hwrite     = 1'b0;
    haddr      = 32'h00000000;
    hwdata     = 32'h00000000;
    htrans     = 2'h0;
    tb_sda_low = 1'b0;
    saw_start  = 1'b0;
    saw_stop   = 1'b0;
    cap        = 9'h000;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_detect();
    t_frame();
    t_force();
    stop_test();
  end

  initial begin
    #1000000;
    fails++;
    stop_test();
  end
endmodule : test_serial_i2c_bus_control
